// ---- spm_manager.sv ----
// power mode manager of a three-port switch, with an AXI4-Lite register slave
// assumes pins are asynchronous (synchronised here); the bus master is on aclk
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module spm_manager
  import spm_pkg::*;
#(
  parameter int UNIT_CYCLES  = SPM_SLEEP_UNIT_CYC,
  parameter int PULSE_PERIOD = SPM_PULSE_PERIOD_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire spm_pins_t   pins,
  output spm_pwr_t         pwr,
  output logic [1:0]       link_pulse
);

  typedef struct packed {
    spm_state_t  st;
    logic        awready;
    logic        wready;
    logic        aw_ok;
    logic        w_ok;
    logic [9:0]  aw_idx;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  p1_ctrl;
    logic [7:0]  p2_ctrl;
    logic [7:0]  gmode;
    logic [7:0]  sleep_dly;
    logic [8:0]  sleep_cnt;
    logic [9:0]  pulse_cnt;
    logic [1:0]  link_pulse;
    spm_pwr_t    pwr;
    logic        strap;
    logic [1:0]  strap_wait;
  } spm_mgr_st_t;

  spm_mgr_st_t r;
  spm_mgr_st_t next_r;
  spm_pins_t   p;
  logic        unit_tick;
  logic        sec_tick;
  logic        wr_go;
  logic        locked;
  logic        energy_any;
  logic        ed_mode;
  logic        run;
  logic [1:0]  port_pd;
  logic [1:0]  ps_idle;
  spm_mode_t   mode;

  spm_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pins),
    .dout    (p)
  );

  spm_tick #(.PERIOD(UNIT_CYCLES)) u_unit (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (unit_tick)
  );

  spm_tick #(.PERIOD(PULSE_PERIOD)) u_second (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (sec_tick)
  );

  // all next-state logic: bus slave, registers, mode machine, power enables
  always_comb begin
    next_r     = r;
    mode       = spm_mode_t'(r.gmode[1:0]);
    energy_any = |p.energy;
    port_pd    = {r.p2_ctrl[SPM_PORT_PD_BIT], r.p1_ctrl[SPM_PORT_PD_BIT]};
    ps_idle    = p.an_en & ~p.link_up & ~p.energy;
    wr_go      = r.aw_ok && r.w_ok && !r.bvalid;
    // registers frozen while the device sleeps; mode register stays open except in chip down
    locked     = (r.st == SPM_ST_SOFT) || (r.st == SPM_ST_ED_SLEEP) ||
                 (r.st == SPM_ST_CHIP_DOWN);

    // address and data are taken in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.aw_ok   = 1'b1;
      next_r.aw_idx  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.w_ok   = 1'b1;
      next_r.wdata  = s_axi_wdata;
      next_r.wstrb0 = s_axi_wstrb[0];
    end

    // only byte lane 0 carries data; other lanes are ignored
    if (wr_go) begin
      next_r.aw_ok  = 1'b0;
      next_r.w_ok   = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = SPM_RESP_OKAY;
      case (r.aw_idx)
        SPM_IDX_P1_CTRL: begin
          if (locked) next_r.bresp = SPM_RESP_SLVERR;
          else if (r.wstrb0) next_r.p1_ctrl = r.wdata[7:0];
        end
        SPM_IDX_P2_CTRL: begin
          if (locked) next_r.bresp = SPM_RESP_SLVERR;
          else if (r.wstrb0) next_r.p2_ctrl = r.wdata[7:0];
        end
        SPM_IDX_GMODE: begin
          // writable in soft power down so the host can wake the chip
          if (r.st == SPM_ST_CHIP_DOWN) next_r.bresp = SPM_RESP_SLVERR;
          else if (r.wstrb0) next_r.gmode = r.wdata[7:0];
        end
        SPM_IDX_SLEEP: begin
          if (locked) next_r.bresp = SPM_RESP_SLVERR;
          else if (r.wstrb0) next_r.sleep_dly = r.wdata[7:0];
        end
        default: next_r.bresp = SPM_RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid  = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready  = 1'b1;
    end

    // reads always answer; contents are retained in every mode
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = SPM_RESP_OKAY;
      next_r.rdata   = 32'h00000000;
      case (s_axi_araddr[11:2])
        SPM_IDX_P1_CTRL: next_r.rdata[7:0] = r.p1_ctrl;
        SPM_IDX_P2_CTRL: next_r.rdata[7:0] = r.p2_ctrl;
        SPM_IDX_GMODE:   next_r.rdata[7:0] = r.gmode;
        SPM_IDX_SLEEP:   next_r.rdata[7:0] = r.sleep_dly;
        SPM_IDX_STATUS:  next_r.rdata[7:0] = {r.strap, energy_any, r.st};
        default:         next_r.rresp = SPM_RESP_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end

    // mode machine; the shutdown pin overrides every mode
    if (!p.chip_shutdown_n) begin
      next_r.st = SPM_ST_CHIP_DOWN;
    end else begin
      case (mode)
        SPM_MODE_NORMAL: next_r.st = SPM_ST_NORMAL;
        SPM_MODE_ENERGY: begin
          if (r.st == SPM_ST_ED_SLEEP)
            next_r.st = energy_any ? SPM_ST_ED_AWAKE : SPM_ST_ED_SLEEP;
          else if ((r.st == SPM_ST_ED_AWAKE) && (r.sleep_cnt > {1'b0, r.sleep_dly}))
            next_r.st = SPM_ST_ED_SLEEP;
          else
            next_r.st = SPM_ST_ED_AWAKE;
        end
        SPM_MODE_SOFT: next_r.st = SPM_ST_SOFT;
        SPM_MODE_SAVE: next_r.st = SPM_ST_SAVE;
        default:       next_r.st = SPM_ST_NORMAL;
      endcase
    end

    // sleep counter: restarts on energy, saturates so it cannot wrap back
    if ((r.st != SPM_ST_ED_AWAKE) || energy_any)
      next_r.sleep_cnt = 9'h000;
    else if (unit_tick && (r.sleep_cnt != SPM_SLEEP_CNT_MAX))
      next_r.sleep_cnt = r.sleep_cnt + 9'h001;

    // link pulses on unconnected ports while energy detect is selected
    ed_mode = (next_r.st == SPM_ST_ED_AWAKE) || (next_r.st == SPM_ST_ED_SLEEP);
    if (sec_tick && ed_mode)
      next_r.pulse_cnt = SPM_PULSE_WIDTH;
    else if (r.pulse_cnt != 10'h000)
      next_r.pulse_cnt = r.pulse_cnt - 10'h001;
    next_r.link_pulse = (next_r.pulse_cnt != 10'h000) && ed_mode ?
                        ~p.link_up & ~port_pd : 2'b00;

    // power enables follow the next state so they line up with it
    run = (next_r.st == SPM_ST_NORMAL) || (next_r.st == SPM_ST_SAVE) ||
          (next_r.st == SPM_ST_ED_AWAKE);
    next_r.pwr.pll_en    = run ||
      ((next_r.st == SPM_ST_ED_SLEEP) && !next_r.gmode[SPM_PLL_OFF_BIT]);
    next_r.pwr.mac_en    = run;
    next_r.pwr.host_en   = run;
    next_r.pwr.phy_tx_en = run ? ~port_pd : 2'b00;
    next_r.pwr.phy_rx_en = (next_r.st == SPM_ST_SAVE) ? ~port_pd & ~ps_idle :
                           (run ? ~port_pd : 2'b00);
    next_r.pwr.chip_down = (next_r.st == SPM_ST_CHIP_DOWN);

    // strap sampled until the synchroniser has flushed its reset value
    if (r.strap_wait != 2'b11) begin
      next_r.strap_wait = r.strap_wait + 2'b01;
      next_r.strap      = p.port3_link_strap;
    end
  end

  // state register; mode field comes out of reset as normal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r           <= '0;
      r.st        <= SPM_ST_NORMAL;
      r.awready   <= 1'b1;
      r.wready    <= 1'b1;
      r.arready   <= 1'b1;
      r.gmode     <= SPM_RST_GMODE;
      r.p1_ctrl   <= SPM_RST_PORT_CTRL;
      r.p2_ctrl   <= SPM_RST_PORT_CTRL;
      r.sleep_dly <= SPM_RST_SLEEP;
      r.pwr       <= SPM_PWR_RST;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rresp   = r.rresp;
  assign s_axi_rdata   = r.rdata;
  assign pwr           = r.pwr;
  assign link_pulse    = r.link_pulse;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_mode;
    !$past(aresetn) |-> (r.gmode[1:0] == 2'b00) && (r.st == SPM_ST_NORMAL);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not normal after reset");

  property p_mode_decode;
    p.chip_shutdown_n && (r.gmode[1:0] == 2'b10) |=> (r.st == SPM_ST_SOFT);
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("code 10 not soft down");

  property p_normal_on;
    (r.st == SPM_ST_NORMAL) |-> r.pwr.pll_en && r.pwr.mac_en && r.pwr.host_en &&
      (r.pwr.phy_tx_en == ~$past(port_pd));
  endproperty
  a_normal_on: assert property (p_normal_on) else $error("normal mode not fully on");

  property p_save_gate;
    (r.st == SPM_ST_SAVE) && (r.pwr.phy_rx_en[0] == 1'b0) |->
      $past(r.p1_ctrl[SPM_PORT_PD_BIT]) || ($past(p.an_en[0]) && !$past(p.link_up[0]));
  endproperty
  a_save_gate: assert property (p_save_gate) else $error("saving without its conditions");

  property p_save_keep;
    (r.st == SPM_ST_SAVE) |-> r.pwr.pll_en && r.pwr.mac_en && r.pwr.host_en;
  endproperty
  a_save_keep: assert property (p_save_keep) else $error("saving lost pll mac or host");

  property p_save_wake;
    (r.st == SPM_ST_SAVE) && (r.gmode[1:0] == 2'b11) && p.chip_shutdown_n &&
      p.energy[0] && !r.p1_ctrl[SPM_PORT_PD_BIT] |=> r.pwr.phy_rx_en[0];
  endproperty
  a_save_wake: assert property (p_save_wake) else $error("receiver not restored");

  property p_go_sleep;
    (r.st == SPM_ST_ED_AWAKE) && (r.gmode[1:0] == 2'b01) && p.chip_shutdown_n &&
      (r.sleep_cnt > {1'b0, r.sleep_dly}) |=> (r.st == SPM_ST_ED_SLEEP);
  endproperty
  a_go_sleep: assert property (p_go_sleep) else $error("no sleep after delay");

  property p_sleep_off;
    (r.st == SPM_ST_ED_SLEEP) |-> !r.pwr.mac_en && !r.pwr.host_en &&
      (r.pwr.phy_tx_en == 2'b00) && (r.pwr.pll_en == !r.gmode[SPM_PLL_OFF_BIT]);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep state left circuits on");

  property p_pulse_width;
    $rose(r.link_pulse[0]) |=> (r.link_pulse[0] || p.link_up[0] || !ed_mode)
      ##1 !r.link_pulse[0];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("link pulse not two cycles");

  property p_wake;
    (r.st == SPM_ST_ED_SLEEP) && (r.gmode[1:0] == 2'b01) && p.chip_shutdown_n &&
      energy_any |=> (r.st == SPM_ST_ED_AWAKE) && r.pwr.mac_en;
  endproperty
  a_wake: assert property (p_wake) else $error("energy did not wake");

  property p_soft_off;
    (r.st == SPM_ST_SOFT) |-> !r.pwr.pll_en && !r.pwr.mac_en && (r.pwr.phy_rx_en == 2'b00);
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("soft down left circuits on");

  property p_soft_exit;
    (r.st == SPM_ST_SOFT) && wr_go && (r.aw_idx == SPM_IDX_GMODE) && r.wstrb0 &&
      (r.wdata[1:0] == 2'b00) && p.chip_shutdown_n ##1 p.chip_shutdown_n
      |=> (r.st == SPM_ST_NORMAL);
  endproperty
  a_soft_exit: assert property (p_soft_exit) else $error("no return from soft down");

  property p_port_pd;
    r.p2_ctrl[SPM_PORT_PD_BIT] ##1 r.p2_ctrl[SPM_PORT_PD_BIT] |->
      !r.pwr.phy_tx_en[1] && !r.pwr.phy_rx_en[1];
  endproperty
  a_port_pd: assert property (p_port_pd) else $error("port phy not powered down");

  property p_shutdown;
    !p.chip_shutdown_n |=> r.pwr.chip_down && !r.pwr.pll_en && !r.pwr.host_en;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown pin ignored");

endmodule

// ---- spm_pkg.sv ----
// constants, state encodings and carrier structs of the switch power mode manager
// assumes one 10 MHz clock (aclk) and a synchronous active-low reset
package spm_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] SPM_IDX_P1_CTRL  = 10'h01d;
  localparam logic [9:0] SPM_IDX_P2_CTRL  = 10'h02d;
  localparam logic [9:0] SPM_IDX_GMODE    = 10'h0c3;
  localparam logic [9:0] SPM_IDX_SLEEP    = 10'h0c4;
  localparam logic [9:0] SPM_IDX_STATUS   = 10'h0c6;

  // field positions
  localparam int SPM_PORT_PD_BIT  = 3;
  localparam int SPM_PLL_OFF_BIT  = 2;

  // reset values
  localparam logic [7:0] SPM_RST_GMODE     = 8'h00;
  localparam logic [7:0] SPM_RST_PORT_CTRL = 8'h00;
  localparam logic [7:0] SPM_RST_SLEEP     = 8'h00;

  // bus responses
  localparam logic [1:0] SPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPM_RESP_SLVERR = 2'h2;

  // timing: clock, sleep-delay unit, link pulse width and period
  localparam int SPM_CLK_PERIOD_NS    = 100;
  localparam int SPM_SLEEP_UNIT_NS    = 1000000;
  localparam int SPM_SLEEP_UNIT_CYC   = SPM_SLEEP_UNIT_NS / SPM_CLK_PERIOD_NS;
  localparam int SPM_PULSE_WIDTH_NS   = 120;
  localparam int SPM_PULSE_WIDTH_CYC  =
    (SPM_PULSE_WIDTH_NS + SPM_CLK_PERIOD_NS - 1) / SPM_CLK_PERIOD_NS;
  localparam int SPM_PULSE_PERIOD_NS  = 1000000000;
  localparam int SPM_PULSE_PERIOD_CYC = SPM_PULSE_PERIOD_NS / SPM_CLK_PERIOD_NS;
  localparam logic [9:0] SPM_PULSE_WIDTH = 10'(SPM_PULSE_WIDTH_CYC);

  // sleep counter saturation value
  localparam logic [8:0] SPM_SLEEP_CNT_MAX = 9'h1ff;

  // global mode field codes
  typedef enum logic [1:0] {
    SPM_MODE_NORMAL = 2'h0,
    SPM_MODE_ENERGY = 2'h1,
    SPM_MODE_SOFT   = 2'h2,
    SPM_MODE_SAVE   = 2'h3
  } spm_mode_t;

  // power manager states
  typedef enum logic [5:0] {
    SPM_ST_NORMAL    = 6'h01,
    SPM_ST_ED_AWAKE  = 6'h02,
    SPM_ST_ED_SLEEP  = 6'h04,
    SPM_ST_SOFT      = 6'h08,
    SPM_ST_SAVE      = 6'h10,
    SPM_ST_CHIP_DOWN = 6'h20
  } spm_state_t;

  // pin inputs from outside the clock domain
  typedef struct packed {
    logic       chip_shutdown_n;
    logic       port3_link_strap;
    logic [1:0] an_en;
    logic [1:0] link_up;
    logic [1:0] energy;
  } spm_pins_t;

  localparam spm_pins_t SPM_PINS_RST = 8'h80;

  // power enables driven to the rest of the chip
  typedef struct packed {
    logic       pll_en;
    logic       mac_en;
    logic       host_en;
    logic [1:0] phy_tx_en;
    logic [1:0] phy_rx_en;
    logic       chip_down;
  } spm_pwr_t;

  // reset lands in normal mode, so every enable is already on
  localparam spm_pwr_t SPM_PWR_RST = 8'hfe;

  typedef struct packed {
    spm_pins_t s1;
    spm_pins_t s2;
  } spm_sync_st_t;

  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } spm_tick_st_t;

endpackage

// ---- spm_sync.sv ----
// two-flop synchroniser for the pin inputs of the power manager
// assumes pins are asynchronous to aclk and change slowly
`timescale 1ns/1ps
module spm_sync
  import spm_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire spm_pins_t din,
  output spm_pins_t      dout
);

  spm_sync_st_t r;
  spm_sync_st_t next_r;

  // first stage feeds only the second stage
  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= {SPM_PINS_RST, SPM_PINS_RST};
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.s2;

endmodule

// ---- spm_tick.sv ----
// free-running divider giving a one-cycle tick every PERIOD clocks
// assumes PERIOD fits in 24 bits and is at least 2
`timescale 1ns/1ps
module spm_tick
  import spm_pkg::*;
#(
  parameter int PERIOD = 10000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);

  localparam logic [23:0] LAST = 24'(PERIOD - 1);

  spm_tick_st_t r;
  spm_tick_st_t next_r;

  // wrap at LAST and pulse once per wrap
  always_comb begin
    next_r      = r;
    next_r.tick = (r.cnt == LAST);
    next_r.cnt  = (r.cnt == LAST) ? 24'h000000 : r.cnt + 24'h000001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule

// ---- spm_cable.sv ----
// cable and link partner model feeding the pin inputs of the power manager
// assumes bench commands change just after a rising aclk edge
`timescale 1ns/1ps
module spm_cable
  import spm_pkg::*;
#(
  parameter int LINK_DLY = 6
) (
  input  wire logic       aclk,
  input  wire logic       plugged,
  input  wire logic [1:0] an_on,
  input  wire logic       shut_n,
  output spm_pins_t       pins
);
  int cnt = 0;

  initial pins = SPM_PINS_RST;

  // energy shows at once, link only after training takes a while
  always @(posedge aclk) begin
    cnt                   <= plugged ? cnt + 1 : 0;
    pins.energy           <= {2{plugged}};
    pins.link_up          <= (plugged && cnt >= LINK_DLY) ? 2'b11 : 2'b00;
    pins.an_en            <= an_on;
    pins.chip_shutdown_n  <= shut_n;
    pins.port3_link_strap <= 1'b1;
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench of the power mode manager: AXI4-Lite master tasks
// assumes short sleep unit and pulse period parameters to keep the run brief
`timescale 1ns/1ps
module tb_top
  import spm_pkg::*;
;
  localparam int UNIT = 4;
  localparam int PER  = 64;
  localparam int SLP  = 5;
  localparam logic [11:0] A_P1 = {SPM_IDX_P1_CTRL, 2'b00};
  localparam logic [11:0] A_P2 = {SPM_IDX_P2_CTRL, 2'b00};
  localparam logic [11:0] A_GM = {SPM_IDX_GMODE, 2'b00};
  localparam logic [11:0] A_SL = {SPM_IDX_SLEEP, 2'b00};
  localparam logic [11:0] A_ST = {SPM_IDX_STATUS, 2'b00};
  localparam logic [1:0]  OK   = SPM_RESP_OKAY;
  localparam logic [1:0]  ERR  = SPM_RESP_SLVERR;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = '0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  spm_pins_t   pins;
  spm_pwr_t    pwr;
  logic [1:0]  link_pulse;
  logic        plugged = 1'b0;
  logic [1:0]  an_on = 2'b00;
  logic        shut_n = 1'b1;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  spm_manager #(.UNIT_CYCLES(UNIT), .PULSE_PERIOD(PER)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pins(pins), .pwr(pwr), .link_pulse(link_pulse));

  spm_cable cable (.aclk(aclk), .plugged(plugged), .an_on(an_on), .shut_n(shut_n), .pins(pins));

  always #50 aclk = ~aclk;

  // watchdog: a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // offer address and data together; bready held until the answer
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    int   n;
    aw_ok = 0;
    w_ok = 0;
    b_ok = 0;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_ok && n < 40) begin
      @(posedge aclk);
      n++;
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b_ok = 1;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
      end
    end
    if (!b_ok) chk("bvalid", 32'h1, 32'h0);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    int   n;
    ar_ok = 0;
    n = 0;
    d = 'x;
    r = 'x;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk($sformatf("rdata %h", a), {24'h0, exp}, d);
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, r});
  endtask

  // poll the status register; state moves a few edges after its cause
  task automatic wait_st(input logic [5:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    d = '0;
    while (d[5:0] !== exp && n < 60) begin
      axi_rd(A_ST, d, r);
      n++;
    end
    chk("state", {26'h0, exp}, {26'h0, d[5:0]});
  endtask

  task automatic wait_pwr(input logic [7:0] exp, input logic [7:0] msk, input string nm);
    int n;
    n = 0;
    while ((pwr & msk) !== exp && n < 12) begin
      @(posedge aclk);
      n++;
    end
    chk(nm, {24'h0, exp}, {24'h0, pwr & msk});
  endtask

  task automatic t_reset();
    int n;
    rd_chk(A_GM, 8'h00, OK);
    rd_chk(A_P1, 8'h00, OK);
    rd_chk(A_P2, 8'h00, OK);
    rd_chk(A_SL, 8'h00, OK);
    wait_st(SPM_ST_NORMAL);
    chk("normal pwr", 32'hfe, {24'h0, pwr});
    rd_chk(A_ST, 8'h81, OK);
    rd_chk(12'h000, 8'h00, ERR);
    axi_wr(A_ST, 8'h3f, ERR);
    n = 0;
    while (n < PER + 4) begin
      @(posedge aclk);
      n++;
      if (link_pulse !== 2'b00) chk("pulse in normal", 32'h0, {30'h0, link_pulse});
    end
    $display("reset test done");
  endtask

  task automatic t_port();
    axi_wr(A_P1, 8'h08, OK);
    rd_chk(A_P1, 8'h08, OK);
    wait_pwr(8'hf4, 8'hff, "port1 down pwr");
    axi_wr(A_P1, 8'h00, OK);
    axi_wr(A_P2, 8'h08, OK);
    wait_pwr(8'hea, 8'hff, "port2 down pwr");
    axi_wr(A_P2, 8'h00, OK);
    axi_wr(A_SL, SLP[7:0], OK);
    rd_chk(A_SL, SLP[7:0], OK);
    $display("port test done");
  endtask

  task automatic t_save();
    axi_wr(A_GM, 8'h03, OK);
    wait_st(SPM_ST_SAVE);
    chk("save no autoneg", 32'hfe, {24'h0, pwr});
    an_on <= 2'b11;
    wait_pwr(8'hf8, 8'hff, "save pwr");
    rd_chk(A_GM, 8'h03, OK);
    plugged <= 1'b1;
    wait_pwr(8'hfe, 8'hff, "save wake pwr");
    plugged <= 1'b0;
    axi_wr(A_GM, 8'h00, OK);
    wait_st(SPM_ST_NORMAL);
    $display("saving test done");
  endtask

  task automatic t_energy();
    int t0, dt, hi, gap, n;
    axi_wr(A_GM, 8'h05, OK);
    t0 = cyc;
    wait_st(SPM_ST_ED_SLEEP);
    dt = cyc - t0;
    chk("sleep not early", 32'h1, {31'h0, dt >= (SLP + 1) * UNIT});
    chk("sleep not late", 32'h1, {31'h0, dt <= (SLP + 2) * UNIT + 10});
    chk("sleep pwr", 32'h00, {24'h0, pwr});
    axi_wr(A_P1, 8'h08, ERR);
    hi = 0;
    gap = 0;
    n = 0;
    while (link_pulse[0] !== 1'b1 && n < 2 * PER) begin
      @(posedge aclk);
      n++;
    end
    chk("pulse port2", 32'h1, {31'h0, link_pulse[1]});
    while (link_pulse[0] === 1'b1 && hi < PER) begin
      @(posedge aclk);
      hi++;
    end
    while (link_pulse[0] !== 1'b1 && gap < 2 * PER) begin
      @(posedge aclk);
      gap++;
    end
    chk("pulse width", SPM_PULSE_WIDTH_CYC, hi);
    chk("pulse period", PER, hi + gap);
    plugged <= 1'b1;
    wait_st(SPM_ST_ED_AWAKE);
    plugged <= 1'b0;
    axi_wr(A_GM, 8'h01, OK);
    wait_st(SPM_ST_ED_SLEEP);
    chk("sleep pll kept", 32'h80, {24'h0, pwr});
    axi_wr(A_GM, 8'h00, OK);
    wait_st(SPM_ST_NORMAL);
    $display("energy test done");
  endtask

  task automatic t_soft();
    axi_wr(A_P1, 8'h08, OK);
    axi_wr(A_GM, 8'h02, OK);
    wait_st(SPM_ST_SOFT);
    chk("soft pwr", 32'h00, {24'h0, pwr & 8'hdf});
    axi_wr(A_P1, 8'h00, ERR);
    rd_chk(A_P1, 8'h08, OK);
    axi_wr(A_GM, 8'h00, OK);
    wait_st(SPM_ST_NORMAL);
    axi_wr(A_P1, 8'h00, OK);
    $display("soft test done");
  endtask

  task automatic t_down();
    shut_n <= 1'b0;
    wait_st(SPM_ST_CHIP_DOWN);
    chk("chip down", 32'h1, {31'h0, pwr.chip_down});
    axi_wr(A_GM, 8'h02, ERR);
    shut_n <= 1'b1;
    wait_st(SPM_ST_NORMAL);
    $display("shutdown test done");
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_port();
    t_save();
    t_energy();
    t_soft();
    t_down();
    end_sim();
  end
endmodule
